// ===== application_special_registers_tb.sv
`timescale 1ns/10ps
module application_special_registers_tb;
	// ----------------------------------------------------------------
	// Stimulus, observation, bookkeeping
	// ----------------------------------------------------------------
	localparam logic [63:0] PAT = 64'hdead_beef_0123_4567;
	localparam logic [63:0] LOW3 = 64'hffff_ffff_ffff_fff8;
	localparam logic [63:0] ONES = 64'hffff_ffff_ffff_ffff;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic rd_i = 1'b0;
	logic leg_i = 1'b0;
	logic wr_i = 1'b0;
	logic sec_i = 1'b0;
	logic tok_i = 1'b1;
	logic [1:0] cs_i = 2'h0;
	logic [8:0] sv = 9'h000;
	logic [6:0] addr_i = 7'h00;
	logic [37:0] cfm_i = 38'h12_3456_789a;
	logic [63:0] wdata_i = 64'h0;
	logic [63:0] ld_i = 64'h1111_2222_3333_4444;
	logic [63:0] pos_i = 64'h8000_0000_0000_0000;
	logic [63:0] bsp_i = 64'h0000_0000_0000_1237;
	logic [63:0] flg_i = 64'h0000_0000_0000_8000;
	logic [63:0] got_d, t0;
	logic got_v, got_p, got_g;
	wire logic rvalid, pf, gf, sbe, retv;
	wire logic [1:0] cpl_w, mode, spriv, retcpl;
	wire logic [2:0] br_w;
	wire logic [13:0] ldist;
	wire logic [37:0] retcfm;
	wire logic [63:0] rdata, spill, s16, xcmp, utok, fpc;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	int i;
	logic [6:0] ta [12] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h19, 7'h20, 7'h24, 7'h28, 7'h40,
		7'h41, 7'h42, 7'h15};
	logic [63:0] tm [12] = '{64'h0000_0000_3fff_001f, 64'h0, LOW3, 64'h7fff_ffff_ffff_ffff,
		ONES, ONES, ONES, ONES, 64'hc3f0_003f_ffff_ffff, ONES, 64'h0000_0000_0000_003f, 64'h0};
	asr_regs uut (.CLK_I(clk_i), .RST_N_I(rst_n_i), .CPL_I(cpl_w), .ITC_SECURE_I(sec_i),
		.RD_I(rd_i), .LEGACY_RD_I(leg_i), .WR_I(wr_i), .ADDR_I(addr_i), .WDATA_I(wdata_i),
		.CALL_I(br_w[0]), .RET_I(br_w[1]), .CFM_I(cfm_i), .LOOP_BR_I(br_w[2]),
		.LD16_I(sv[0]), .LD16_DATA_I(ld_i), .SPILL_I(sv[1]), .SPILL_POS_I(pos_i),
		.SPILL_TOKEN_I(tok_i), .BSP_LOAD_I(sv[2]), .BSP_I(bsp_i), .SPILL_ADV_I(sv[3]),
		.FP_NATIVE_I(sv[4]), .FP_FLAGS_I(flg_i), .RDATA_O(rdata), .RVALID_O(rvalid),
		.PRIV_FAULT_O(pf), .GP_FAULT_O(gf), .STACK_MODE_O(mode), .STACK_PRIV_O(spriv),
		.STACK_BE_O(sbe), .LOAD_DIST_O(ldist), .SPILL_ADDR_O(spill), .STORE16_DATA_O(s16),
		.XCHG_CMP_O(xcmp), .USER_TOKEN_O(utok), .FP_CTRL_O(fpc), .RET_VALID_O(retv),
		.RET_CFM_O(retcfm), .RET_CPL_O(retcpl));
	asr_branch_model bru (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(sv[8:5]), .cpl_set_i(cs_i),
		.ret_valid_i(retv), .ret_cpl_i(retcpl), .br_o(br_w), .cpl_o(cpl_w));
	always #10 clk_i = ~clk_i;
	// Whole run is under two hundred cycles; a hang runs on to the cap at cycle 4000 and fails the run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			summarize();
		end
	end
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [63:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic leg);
		int n;
		@(posedge clk_i);
		rd_i <= ~leg;
		leg_i <= leg;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		leg_i <= 1'b0;
		{got_v, got_p, got_g, got_d} = 67'h0;
		for (n = 0; n < 3; n++) begin
			@(negedge clk_i);
			if ((rvalid | pf | gf) === 1'b1) begin
				{got_v, got_p, got_g, got_d} = {rvalid, pf, gf, rdata};
				break;
			end
		end
	endtask : rd
	task automatic rdchk(input logic [6:0] a, input logic [63:0] exp);
		rd(a, 1'b0);
		chk({63'h0, got_v}, 64'h1);
		chk(got_d, exp);
	endtask : rdchk
	// Bits 4:0 block strobes, 7:5 call/return/loop, 8 privilege load
	task automatic hit(input logic [8:0] m, input logic [1:0] c);
		@(posedge clk_i);
		sv <= m;
		cs_i <= c;
		@(posedge clk_i);
		sv <= 9'h000;
		@(posedge clk_i);
		@(negedge clk_i);
		got_v = retv;
	endtask : hit
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 12; i++) begin
			wr(ta[i], PAT);
			rdchk(ta[i], PAT & tm[i]);
		end
		chk(spill, PAT & LOW3);
		chk(s16, PAT);
		chk(xcmp, PAT);
		chk(utok, PAT);
		chk(fpc, PAT);
		chk({50'h0, ldist}, 64'h0123);
		chk({62'h0, mode}, 64'h0);
		chk({62'h0, spriv}, 64'h1);
		hit(9'h100, 2'h2);
		wr(7'h10, 64'h0000_0000_0000_0010);
		rdchk(7'h10, 64'h0000_0000_0000_0018);
		chk({63'h0, sbe}, 64'h1);
		chk({62'h0, spriv}, 64'h2);
		hit(9'h001, 2'h0);
		rdchk(7'h19, ld_i);
		hit(9'h004, 2'h0);
		rdchk(7'h11, 64'h0000_0000_0000_1230);
		hit(9'h008, 2'h0);
		rdchk(7'h12, (PAT & LOW3) + 64'h8);
		hit(9'h002, 2'h0);
		pos_i <= 64'h0000_0000_0000_0008;
		hit(9'h002, 2'h0);
		rdchk(7'h13, 64'h5ead_beef_0123_456f);
		hit(9'h010, 2'h0);
		rdchk(7'h28, 64'hdead_beef_0123_c567);
		hit(9'h080, 2'h0);
		hit(9'h080, 2'h0);
		rdchk(7'h41, PAT - 64'h2);
		hit(9'h100, 2'h3);
		hit(9'h020, 2'h0);
		rdchk(7'h40, {2'h3, 4'h0, 6'h27, 14'h0, cfm_i});
		wr(7'h42, 64'h5);
		hit(9'h100, 2'h1);
		hit(9'h040, 2'h0);
		chk({63'h0, got_v}, 64'h1);
		chk({26'h0, retcfm}, {26'h0, cfm_i});
		chk({62'h0, retcpl}, 64'h3);
		rdchk(7'h42, 64'h27);
		hit(9'h100, 2'h0);
		hit(9'h020, 2'h0);
		hit(9'h100, 2'h2);
		hit(9'h040, 2'h0);
		chk({62'h0, retcpl}, 64'h2);
		hit(9'h100, 2'h0);
		wr(7'h2c, 64'h0000_0000_0000_1000);
		rd(7'h2c, 1'b0);
		chk({63'h0, got_d > 64'h1000 && got_d < 64'h1004}, 64'h1);
		t0 = got_d;
		rd(7'h2c, 1'b0);
		chk(got_d, t0 + 64'h2);
		hit(9'h100, 2'h3);
		wr(7'h2c, 64'h0);
		rd(7'h2c, 1'b0);
		chk({63'h0, got_d > t0}, 64'h1);
		sec_i <= 1'b1;
		rd(7'h2c, 1'b0);
		chk({61'h0, got_v, got_p, got_g}, 64'h2);
		rd(7'h2c, 1'b1);
		chk({61'h0, got_v, got_p, got_g}, 64'h1);
		chk(got_d, 64'h0);
		hit(9'h100, 2'h0);
		rd(7'h2c, 1'b1);
		chk({63'h0, got_v && got_d > t0}, 64'h1);
		summarize();
	end
endmodule : application_special_registers_tb

// ===== asr_branch_model.sv
`timescale 1ns/10ps
module asr_branch_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] req_i,
	input wire logic [1:0] cpl_set_i,
	input wire logic ret_valid_i,
	input wire logic [1:0] ret_cpl_i,
	output logic [2:0] br_o,
	output logic [1:0] cpl_o
);
	// ----------------------------------------------------------------
	// Branch unit: one-cycle strobes and privilege tracking
	// ----------------------------------------------------------------
	logic [2:0] br_r = 3'h0;
	logic [1:0] cpl_r = 2'h0;
	assign br_o = br_r;
	assign cpl_o = cpl_r;
	always @(posedge clk_i) begin
		br_r <= req_i[2:0];
	end
	// Returned level taken as is; refusing a raise is the block's job
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			cpl_r <= 2'h0;
		end else if (req_i[3]) begin
			cpl_r <= cpl_set_i;
		end else if (ret_valid_i) begin
			cpl_r <= ret_cpl_i;
		end
	end
endmodule : asr_branch_model

// ===== asr_pkg.sv
package asr_pkg;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_STACK_ENGINE_CONFIG = 7'h10;
	localparam logic [6:0] ADDR_BACKING_STORE_POINTER = 7'h11;
	localparam logic [6:0] ADDR_BACKING_SPILL_POINTER = 7'h12;
	localparam logic [6:0] ADDR_STACK_TOKEN_COLLECTION = 7'h13;
	localparam logic [6:0] ADDR_COMPARE_STORE_DATA = 7'h19;
	localparam logic [6:0] ADDR_EXCHANGE_COMPARE_VALUE = 7'h20;
	localparam logic [6:0] ADDR_USER_TOKEN_COLLECTION = 7'h24;
	localparam logic [6:0] ADDR_FLOAT_STATUS = 7'h28;
	localparam logic [6:0] ADDR_INTERVAL_TIME_COUNTER = 7'h2c;
	localparam logic [6:0] ADDR_PREVIOUS_FUNCTION_STATE = 7'h40;
	localparam logic [6:0] ADDR_LOOP_COUNTER = 7'h41;
	localparam logic [6:0] ADDR_EPILOG_COUNTER = 7'h42;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PL_LSB = 2;
	localparam int CFG_BE_BIT = 4;
	localparam int CFG_LOAD_LSB = 16;
	localparam int CFG_LOAD_W = 14;
	localparam int PFS_PFM_LSB = 0;
	localparam int PFS_PFM_W = 38;
	localparam int PFS_PEC_LSB = 52;
	localparam int PFS_PPL_LSB = 62;
	localparam int EPILOG_W = 6;
	localparam logic [63:0] CFG_WMASK = 64'h0000_0000_3FFF_001F;
	localparam logic [63:0] PFS_WMASK = 64'hC3F0_003F_FFFF_FFFF;
	localparam logic [63:0] TOKEN_WMASK = 64'h7FFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] PTR_WMASK = 64'hFFFF_FFFF_FFFF_FFF8;
	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [63:0] RESET_WORD = 64'h0000_0000_0000_0000;
	localparam logic [1:0] PL_MOST = 2'h0;
	localparam logic [3:0] ITC_RATIO = 4'h1;
	typedef enum logic [1:0] {
		ASR_LAZY = 2'b00,
		ASR_STORE_EAGER = 2'b01,
		ASR_LOAD_EAGER = 2'b10,
		ASR_BOTH_EAGER = 2'b11
	} asr_mode_t;
endpackage : asr_pkg

// ===== asr_regs.sv
`timescale 1ns/10ps
module asr_regs (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [1:0] CPL_I,
	input wire logic ITC_SECURE_I,
	input wire logic RD_I,
	input wire logic LEGACY_RD_I,
	input wire logic WR_I,
	input wire logic [6:0] ADDR_I,
	input wire logic [63:0] WDATA_I,
	input wire logic CALL_I,
	input wire logic RET_I,
	input wire logic [37:0] CFM_I,
	input wire logic LOOP_BR_I,
	input wire logic LD16_I,
	input wire logic [63:0] LD16_DATA_I,
	input wire logic SPILL_I,
	input wire logic [63:0] SPILL_POS_I,
	input wire logic SPILL_TOKEN_I,
	input wire logic BSP_LOAD_I,
	input wire logic [63:0] BSP_I,
	input wire logic SPILL_ADV_I,
	input wire logic FP_NATIVE_I,
	input wire logic [63:0] FP_FLAGS_I,
	output logic [63:0] RDATA_O,
	output logic RVALID_O,
	output logic PRIV_FAULT_O,
	output logic GP_FAULT_O,
	output logic [1:0] STACK_MODE_O,
	output logic [1:0] STACK_PRIV_O,
	output logic STACK_BE_O,
	output logic [13:0] LOAD_DIST_O,
	output logic [63:0] SPILL_ADDR_O,
	output logic [63:0] STORE16_DATA_O,
	output logic [63:0] XCHG_CMP_O,
	output logic [63:0] USER_TOKEN_O,
	output logic [63:0] FP_CTRL_O,
	output logic RET_VALID_O,
	output logic [37:0] RET_CFM_O,
	output logic [1:0] RET_CPL_O
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [63:0] cfg_r, bsp_r, spill_r, stok_r, csd_r, ccv_r, utok_r, float_status_r;
	logic [63:0] itc_r, pfs_r, lc_r;
	logic [5:0] ec_r;
	logic [3:0] div_r;
	logic wr_ok, rd_itc_bad;
	logic [1:0] pl_req;

	function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
		return a == r;
	endfunction : hit

	function automatic logic [63:0] merge(input logic [63:0] old, input logic [63:0] nw,
		input logic [63:0] m);
		return (old & ~m) | (nw & m);
	endfunction : merge

	assign wr_ok = WR_I;
	assign pl_req = WDATA_I[asr_pkg::CFG_PL_LSB +: 2];
	assign rd_itc_bad = ITC_SECURE_I && (CPL_I != asr_pkg::PL_MOST)
		&& hit(ADDR_I, asr_pkg::ADDR_INTERVAL_TIME_COUNTER);

	// ----------------------------------------------------------------
	// Stack engine configuration
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			cfg_r <= asr_pkg::RESET_WORD;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_STACK_ENGINE_CONFIG)) begin
			// Larger code is less privileged; clamp to current level
			if (pl_req < CPL_I) begin
				cfg_r <= merge(cfg_r, {WDATA_I[63:4], CPL_I, WDATA_I[1:0]},
					asr_pkg::CFG_WMASK);
			end else begin
				cfg_r <= merge(cfg_r, WDATA_I, asr_pkg::CFG_WMASK);
			end
		end
	end

	// Eager modes are hints only; engine always runs lazy
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			STACK_MODE_O <= 2'b00;
			STACK_PRIV_O <= 2'b00;
			STACK_BE_O <= 1'b0;
			LOAD_DIST_O <= 14'h0000;
		end else begin
			STACK_MODE_O <= asr_pkg::ASR_LAZY;
			STACK_PRIV_O <= cfg_r[asr_pkg::CFG_PL_LSB +: 2];
			STACK_BE_O <= cfg_r[asr_pkg::CFG_BE_BIT];
			LOAD_DIST_O <= cfg_r[asr_pkg::CFG_LOAD_LSB +: asr_pkg::CFG_LOAD_W];
		end
	end

	// ----------------------------------------------------------------
	// Backing store pointers and token collection
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			bsp_r <= asr_pkg::RESET_WORD;
		end else if (BSP_LOAD_I) begin
			bsp_r <= BSP_I & asr_pkg::PTR_WMASK;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			spill_r <= asr_pkg::RESET_WORD;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_BACKING_SPILL_POINTER)) begin
			spill_r <= WDATA_I;
		end else if (SPILL_ADV_I) begin
			spill_r <= spill_r + 64'h0000_0000_0000_0008;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			SPILL_ADDR_O <= asr_pkg::RESET_WORD;
		end else begin
			SPILL_ADDR_O <= spill_r & asr_pkg::PTR_WMASK;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			stok_r <= asr_pkg::RESET_WORD;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_STACK_TOKEN_COLLECTION)) begin
			stok_r <= WDATA_I & asr_pkg::TOKEN_WMASK;
		end else if (SPILL_I) begin
			stok_r <= (stok_r | (SPILL_POS_I & {64{SPILL_TOKEN_I}}))
				& asr_pkg::TOKEN_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Operand registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			csd_r <= asr_pkg::RESET_WORD;
		end else if (LD16_I) begin
			csd_r <= LD16_DATA_I;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_COMPARE_STORE_DATA)) begin
			csd_r <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ccv_r <= asr_pkg::RESET_WORD;
			utok_r <= asr_pkg::RESET_WORD;
		end else begin
			if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_EXCHANGE_COMPARE_VALUE)) begin
				ccv_r <= WDATA_I;
			end
			if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_USER_TOKEN_COLLECTION)) begin
				utok_r <= WDATA_I;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			STORE16_DATA_O <= asr_pkg::RESET_WORD;
			XCHG_CMP_O <= asr_pkg::RESET_WORD;
			USER_TOKEN_O <= asr_pkg::RESET_WORD;
			FP_CTRL_O <= asr_pkg::RESET_WORD;
		end else begin
			STORE16_DATA_O <= csd_r;
			XCHG_CMP_O <= ccv_r;
			USER_TOKEN_O <= utok_r;
			FP_CTRL_O <= float_status_r;
		end
	end

	// ----------------------------------------------------------------
	// Float status
	// ----------------------------------------------------------------
	// Legacy float ops never reach this register
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			float_status_r <= asr_pkg::RESET_WORD;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_FLOAT_STATUS)) begin
			float_status_r <= WDATA_I;
		end else if (FP_NATIVE_I) begin
			float_status_r <= float_status_r | FP_FLAGS_I;
		end
	end

	// ----------------------------------------------------------------
	// Interval counter
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			div_r <= 4'h0;
		end else if (div_r == asr_pkg::ITC_RATIO - 4'h1) begin
			div_r <= 4'h0;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			itc_r <= asr_pkg::RESET_WORD;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_INTERVAL_TIME_COUNTER)
			&& CPL_I == asr_pkg::PL_MOST) begin
			itc_r <= WDATA_I;
		end else if (div_r == asr_pkg::ITC_RATIO - 4'h1) begin
			itc_r <= itc_r + 64'h0000_0000_0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Previous function state, loop and epilog
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pfs_r <= asr_pkg::RESET_WORD;
		end else if (CALL_I) begin
			pfs_r <= {CPL_I, 4'h0, ec_r, 14'h0000, CFM_I};
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_PREVIOUS_FUNCTION_STATE)) begin
			pfs_r <= WDATA_I & asr_pkg::PFS_WMASK;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ec_r <= 6'h00;
		end else if (RET_I) begin
			ec_r <= pfs_r[asr_pkg::PFS_PEC_LSB +: asr_pkg::EPILOG_W];
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_EPILOG_COUNTER)) begin
			ec_r <= WDATA_I[5:0];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			RET_VALID_O <= 1'b0;
			RET_CFM_O <= 38'h00_0000_0000;
			RET_CPL_O <= 2'b00;
		end else begin
			RET_VALID_O <= RET_I;
			if (RET_I) begin
				RET_CFM_O <= pfs_r[asr_pkg::PFS_PFM_LSB +: asr_pkg::PFS_PFM_W];
				// Numerically lower is more privileged
				RET_CPL_O <= (pfs_r[asr_pkg::PFS_PPL_LSB +: 2] > CPL_I)
					? pfs_r[asr_pkg::PFS_PPL_LSB +: 2] : CPL_I;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			lc_r <= asr_pkg::RESET_WORD;
		end else if (wr_ok && hit(ADDR_I, asr_pkg::ADDR_LOOP_COUNTER)) begin
			lc_r <= WDATA_I;
		end else if (LOOP_BR_I) begin
			lc_r <= lc_r - 64'h0000_0000_0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= asr_pkg::RESET_WORD;
			RVALID_O <= 1'b0;
			PRIV_FAULT_O <= 1'b0;
			GP_FAULT_O <= 1'b0;
		end else begin
			RVALID_O <= (RD_I && !rd_itc_bad)
				|| (LEGACY_RD_I && !(ITC_SECURE_I && CPL_I != asr_pkg::PL_MOST));
			PRIV_FAULT_O <= RD_I && rd_itc_bad;
			GP_FAULT_O <= LEGACY_RD_I && ITC_SECURE_I && CPL_I != asr_pkg::PL_MOST;
			if (LEGACY_RD_I) begin
				RDATA_O <= ITC_SECURE_I && CPL_I != asr_pkg::PL_MOST ?
					asr_pkg::RESET_WORD : itc_r;
			end else if (RD_I && !rd_itc_bad) begin
				unique case (ADDR_I)
					asr_pkg::ADDR_STACK_ENGINE_CONFIG: RDATA_O <= cfg_r;
					asr_pkg::ADDR_BACKING_STORE_POINTER: RDATA_O <= bsp_r;
					asr_pkg::ADDR_BACKING_SPILL_POINTER: RDATA_O <= spill_r & asr_pkg::PTR_WMASK;
					asr_pkg::ADDR_STACK_TOKEN_COLLECTION: RDATA_O <= stok_r;
					asr_pkg::ADDR_COMPARE_STORE_DATA: RDATA_O <= csd_r;
					asr_pkg::ADDR_EXCHANGE_COMPARE_VALUE: RDATA_O <= ccv_r;
					asr_pkg::ADDR_USER_TOKEN_COLLECTION: RDATA_O <= utok_r;
					asr_pkg::ADDR_FLOAT_STATUS: RDATA_O <= float_status_r;
					asr_pkg::ADDR_INTERVAL_TIME_COUNTER: RDATA_O <= itc_r;
					asr_pkg::ADDR_PREVIOUS_FUNCTION_STATE: RDATA_O <= pfs_r;
					asr_pkg::ADDR_LOOP_COUNTER: RDATA_O <= lc_r;
					asr_pkg::ADDR_EPILOG_COUNTER: RDATA_O <= {58'h0, ec_r};
					default: RDATA_O <= asr_pkg::RESET_WORD;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence call_s;
		CALL_I;
	endsequence
	sequence ret_s;
		RET_I && !CALL_I;
	endsequence

	token_top_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		stok_r[63] == 1'b0) else $error("token bit 63 set");
	cfg_priv_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		wr_ok && hit(ADDR_I, asr_pkg::ADDR_STACK_ENGINE_CONFIG) |=>
		cfg_r[3:2] >= $past(CPL_I)) else $error("config privilege raised");
	call_save_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		call_s |=> pfs_r[37:0] == $past(CFM_I) && pfs_r[63:62] == $past(CPL_I)
		&& pfs_r[57:52] == $past(ec_r)) else $error("call save wrong");
	ret_priv_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ret_s |=> RET_VALID_O && RET_CPL_O >= $past(CPL_I)) else $error("return raised privilege");
	ret_epilog_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ret_s |=> ec_r == $past(pfs_r[57:52])) else $error("epilog not restored");
	itc_wr_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		WR_I && CPL_I != 2'b00 && hit(ADDR_I, asr_pkg::ADDR_INTERVAL_TIME_COUNTER) |=>
		itc_r == $past(itc_r) + 64'h1) else $error("unprivileged counter write");
	itc_fault_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		RD_I && rd_itc_bad |=> PRIV_FAULT_O && !RVALID_O) else $error("no privilege fault");
	legacy_gp_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		LEGACY_RD_I && ITC_SECURE_I && CPL_I != 2'b00 |=> GP_FAULT_O)
		else $error("no protection fault");
	loop_dec_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		LOOP_BR_I && !WR_I |=> lc_r == $past(lc_r) - 64'h1) else $error("loop not decremented");
	bsp_low_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		bsp_r[2:0] == 3'b000 && SPILL_ADDR_O[2:0] == 3'b000) else $error("pointer low bits");
endmodule : asr_regs
